// file: hdl/cdr_ctrl_params.svh
// Register offsets, field positions, reset values and timing figures of the output and loop control.
`ifndef CDR_CTRL_PARAMS_SVH
`define CDR_CTRL_PARAMS_SVH
`define OUTPUT_CONTROL_OFFSET 8'h1e
`define OUTPUT_SWING_OFFSET   8'h1f
`define LOOP_CONTROL_OFFSET   8'h20
`define LOOP_STATUS_OFFSET    8'h21
`define RATIO_OFFSET          8'h22
`define OC_DATA_OFF_BIT       4
`define OC_CLOCK_OFF_BIT      3
`define OC_DDR_OFF_BIT        2
`define OC_DATA_INV_BIT       1
`define OC_CLOCK_INV_BIT      0
`define OC_WRITE_MASK         8'h3f
`define SWING_RESET           8'hcc
`define SWING_MIN_VALID       4'h4
`define LOCK_PPM              250
`define UNLOCK_PPM            1000
`define ADAPT_MIN_RATE_MBPS   5500
`define FIFO_DEPTH_UI         32
`define DCO_MIN               16'h0000
`define DCO_MAX               16'hffff
`define DIV_MAX               4'ha
`endif

// file: hdl/cdr_ctrl_pkg.sv
// Types shared by the output and acquisition control block.
package cdr_ctrl_pkg;
  typedef enum logic [1:0] {ACQ_RESET, ACQ_SEARCH, ACQ_TRACK} acq_state_type;
endpackage

// file: hdl/cdr_output_and_acquisition_control.sv
// Output control, output swing registers and frequency acquisition loop of a clock and data recovery.
// Behaviour
// - Data-off bit four set disables the serial data output driver.
// - Clock-off bit three set disables the recovered clock output driver.
// - Bit two zero enables double-rate clock, one disables it.
// - Data-invert bit one set inverts retimed data polarity.
// - Clock-invert bit zero set inverts recovered clock polarity.
// - Upper swing nibble sets data amplitude, resets to 0xc.
// - Lower swing nibble sets clock amplitude, resets to 0xc.
// - Adaptive equalizer allowed only above 5.5 Gbps; manual always.
// - Frequency loop sets oscillator start value and downsampler ratio.
// - Clock lagging data raises oscillator and shortens phase delay.
// - Integrating loop filter drives static phase error to zero.
// - Oscillator word saturates; phase shifter takes over tracking.
// - Elastic buffer tolerates up to 32 UI of mismatch.
// - In data mode, acquire to within 250 ppm, then enable the phase loop.
// - In data mode, beyond 1000 ppm flag lock loss, restart at lowest oscillator, ratio one; a restart in reference mode loads the written ratio.
`timescale 1ns/1ps
`include "cdr_ctrl_params.svh"

module cdr_output_and_acquisition_control #(
  parameter int DCO_WIDTH = 16  // Oscillator control word width.
) (
  input  wire logic                 ref_clk_i,         // 40 MHz clock.
  input  wire logic                 rst_n_i,           // Async reset, active low.
  input  wire logic                 reg_wr_i,          // Register write strobe.
  input  wire logic [7:0]           reg_addr_i,        // Register address.
  input  wire logic [7:0]           reg_wdata_i,       // Register write data.
  output logic      [7:0]           reg_rdata_o,       // Register read data.
  input  wire logic                 sample_fast_i,     // Sampling clock above data rate (pin).
  input  wire logic                 within_lock_i,     // Frequency within 250 ppm (pin).
  input  wire logic                 beyond_unlock_i,   // Frequency off by over 1000 ppm (pin).
  input  wire logic                 phase_lag_i,       // Phase detector says clock lags (pin).
  input  wire logic                 phase_valid_i,     // Phase detector decision valid (pin).
  input  wire logic                 rate_above_adapt_i,// Data rate above 5.5 Gbps (pin).
  input  wire logic                 ref_mode_i,        // Lock-to-reference mode (pin).
  input  wire logic                 data_i,            // Recovered data bit (same clock).
  input  wire logic                 clk_phase_i,       // Recovered clock level (same clock).
  output logic                      data_o,            // Retimed data output.
  output logic                      data_oe_o,         // Data output driver enable.
  output logic                      clock_o,           // Recovered clock output.
  output logic                      clock_oe_o,        // Clock output driver enable.
  output logic                      ddr_en_o,          // Double-rate clock enable.
  output logic      [3:0]           data_swing_o,      // Data amplitude code.
  output logic      [3:0]           clock_swing_o,     // Clock amplitude code.
  output logic                      eq_adapt_ok_o,     // Adaptive equalizer allowed.
  output logic      [DCO_WIDTH-1:0] dco_word_o,        // Oscillator control word.
  output logic      [3:0]           div_ratio_o,       // Downsampler ratio exponent.
  output logic      [4:0]           shifter_o,         // Phase shifter delay code.
  output logic                      phase_loop_en_o,   // Phase loop enabled.
  output logic                      lock_lost_flag_o   // Lock lost flag.
);
  import cdr_ctrl_pkg::*;

  typedef struct packed {
    logic [1:0]           s0;       // First sync stage, read only by s1.
    logic [1:0]           s1;
    logic [4:0]           pa;       // First stage of the other pins.
    logic [4:0]           pb;
    logic [7:0]           ctrl;
    logic [7:0]           swing;
    logic [7:0]           ratio;
    logic                 adapt_req;
    acq_state_type        st;
    logic [DCO_WIDTH-1:0] digital_oscillator;
    logic [3:0]           step;
    logic [3:0]           div;
    logic [4:0]           shift;
    logic                 lock_lost;
    logic                 lock_lost_sticky;
    logic [7:0]           rdata;
    logic                 dout;
    logic                 doe;
    logic                 cout;
    logic                 coe;
    logic                 ddr_en;
    logic                 adapt_ok;
    logic                 tracking;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // Saturating add or subtract keeps the oscillator word pinned at its range end.
  function automatic logic [DCO_WIDTH-1:0] sat_step(input logic [DCO_WIDTH-1:0] w,
                                                    input logic [3:0] sh,
                                                    input logic up);
    logic [DCO_WIDTH:0] d;
    logic [DCO_WIDTH:0] r;
    d = (DCO_WIDTH+1)'(1) << sh;
    if (up) begin
      r = {1'b0, w} + d;
      sat_step = r[DCO_WIDTH] ? {DCO_WIDTH{1'b1}} : r[DCO_WIDTH-1:0];
    end else begin
      r = {1'b0, w} - d;
      sat_step = r[DCO_WIDTH] ? '0 : r[DCO_WIDTH-1:0];
    end
  endfunction

  logic fast_s;
  logic lockwin_s;
  logic unlock_s;
  logic lag_s;
  logic pvalid_s;
  logic adapt_s;
  logic refm_s;
  logic dco_at_end;

  assign fast_s     = state_reg.s1[0];
  assign lockwin_s  = state_reg.s1[1];
  assign unlock_s   = state_reg.pb[0];
  assign lag_s      = state_reg.pb[1];
  assign pvalid_s   = state_reg.pb[2];
  assign adapt_s    = state_reg.pb[3];
  assign refm_s     = state_reg.pb[4];
  assign dco_at_end = (state_reg.digital_oscillator == {DCO_WIDTH{1'b1}}) || (state_reg.digital_oscillator == '0);

  always_comb begin
    state_next       = state_reg;
    state_next.s0    = {within_lock_i, sample_fast_i};
    state_next.s1    = state_reg.s0;
    state_next.pa    = {ref_mode_i, rate_above_adapt_i, phase_valid_i, phase_lag_i,
                        beyond_unlock_i};
    state_next.pb    = state_reg.pa;

    if (reg_wr_i) begin
      case (reg_addr_i)
        `OUTPUT_CONTROL_OFFSET: state_next.ctrl = reg_wdata_i & `OC_WRITE_MASK;
        `OUTPUT_SWING_OFFSET:   state_next.swing = reg_wdata_i;
        `RATIO_OFFSET:          state_next.ratio = reg_wdata_i;
        `LOOP_CONTROL_OFFSET:   state_next.adapt_req = reg_wdata_i[0];
        default: ;
      endcase
    end

    case (reg_addr_i)
      `OUTPUT_CONTROL_OFFSET: state_next.rdata = state_reg.ctrl;
      `OUTPUT_SWING_OFFSET:   state_next.rdata = state_reg.swing;
      `RATIO_OFFSET:          state_next.rdata = state_reg.ratio;
      `LOOP_CONTROL_OFFSET:   state_next.rdata = {7'h00, state_reg.adapt_req};
      `LOOP_STATUS_OFFSET:    state_next.rdata = {4'h0, state_reg.div};
      default:                state_next.rdata = 8'h00;
    endcase

    // Status read shows the live loop state and the lock-lost flag.
    if (reg_addr_i == `LOOP_STATUS_OFFSET) begin
      state_next.rdata = {state_reg.lock_lost_sticky, state_reg.lock_lost,
                          (state_reg.st == ACQ_TRACK), 1'b0, state_reg.div};
    end

    // A new loss beats a clearing write, so no event goes missing.
    if (reg_wr_i && reg_addr_i == `LOOP_STATUS_OFFSET && reg_wdata_i[7]) begin
      state_next.lock_lost_sticky = 1'b0;
    end

    case (state_reg.st)
      ACQ_RESET: begin
        state_next.digital_oscillator  = '0;
        state_next.div  = 4'h0;
        state_next.step = 4'(DCO_WIDTH - 4);
        state_next.lock_lost = 1'b1;
        state_next.st   = refm_s ? ACQ_TRACK : ACQ_SEARCH;
        if (refm_s) begin
          state_next.div = state_reg.ratio[3:0];
        end
      end
      ACQ_SEARCH: begin
        if (lockwin_s) begin
          state_next.lock_lost = 1'b0;
          state_next.st  = ACQ_TRACK;
        end else if (fast_s) begin
          if (state_reg.div != `DIV_MAX) begin
            state_next.div = state_reg.div + 4'h1;
          end
          state_next.digital_oscillator = '0;
        end else begin
          state_next.digital_oscillator = sat_step(state_reg.digital_oscillator, state_reg.step, 1'b1);
          if (state_reg.step != 4'h0) begin
            state_next.step = state_reg.step - 4'h1;
          end
        end
      end
      ACQ_TRACK: begin
        if (unlock_s && !refm_s) begin
          state_next.lock_lost        = 1'b1;
          state_next.lock_lost_sticky = 1'b1;
          state_next.st         = ACQ_RESET;
        end else if (pvalid_s) begin
          // Integrator: each decision nudges the word, so steady error averages out.
          state_next.digital_oscillator = sat_step(state_reg.digital_oscillator, 4'h0, lag_s);
          if (dco_at_end || lag_s) begin
            // Phase shifter wraps freely, standing in for its infinite range.
            state_next.shift = lag_s ? state_reg.shift - 5'h1 : state_reg.shift + 5'h1;
          end
        end
      end
      default: state_next.st = ACQ_RESET;
    endcase

    state_next.dout = data_i ^ state_reg.ctrl[`OC_DATA_INV_BIT];
    state_next.doe  = !state_reg.ctrl[`OC_DATA_OFF_BIT];
    state_next.cout = clk_phase_i ^ state_reg.ctrl[`OC_CLOCK_INV_BIT];
    state_next.coe  = !state_reg.ctrl[`OC_CLOCK_OFF_BIT];
    // Taken from the next state so these pins keep the timing of a plain decode.
    state_next.ddr_en   = !state_next.ctrl[`OC_DDR_OFF_BIT];
    state_next.adapt_ok = state_next.adapt_req & state_next.pb[3];
    state_next.tracking = (state_next.st == ACQ_TRACK);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg       <= '0;
      state_reg.swing <= `SWING_RESET;
      state_reg.st    <= ACQ_RESET;
      state_reg.doe   <= 1'b1;
      state_reg.coe   <= 1'b1;
      state_reg.lock_lost <= 1'b1;
      state_reg.ddr_en    <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // The elastic buffer depth of 32 UI lives in the analog retimer; the code
  // width of the shifter here covers that span.
  assign reg_rdata_o      = state_reg.rdata;
  assign data_o           = state_reg.dout;
  assign data_oe_o        = state_reg.doe;
  assign clock_o          = state_reg.cout;
  assign clock_oe_o       = state_reg.coe;
  assign ddr_en_o         = state_reg.ddr_en;
  assign data_swing_o     = state_reg.swing[7:4];
  assign clock_swing_o    = state_reg.swing[3:0];
  assign eq_adapt_ok_o    = state_reg.adapt_ok;
  assign dco_word_o       = state_reg.digital_oscillator;
  assign div_ratio_o      = state_reg.div;
  assign shifter_o        = state_reg.shift;
  assign phase_loop_en_o  = state_reg.tracking;
  assign lock_lost_flag_o = state_reg.lock_lost;

  property p_data_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      state_reg.ctrl[`OC_DATA_OFF_BIT] |=> !data_oe_o;
  endproperty
  a_data_off: assert property (p_data_off) else $error("data driver not disabled");

  property p_clock_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !state_reg.ctrl[`OC_CLOCK_OFF_BIT] |=> clock_oe_o;
  endproperty
  a_clock_off: assert property (p_clock_off) else $error("clock driver not enabled");

  property p_ddr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      reg_wr_i && reg_addr_i == `OUTPUT_CONTROL_OFFSET |=> ddr_en_o == !$past(reg_wdata_i[2]);
  endproperty
  a_ddr: assert property (p_ddr) else $error("double-rate enable wrong");

  property p_data_inv;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      1'b1 |=> data_o == ($past(data_i) ^ $past(state_reg.ctrl[`OC_DATA_INV_BIT]));
  endproperty
  a_data_inv: assert property (p_data_inv) else $error("data polarity wrong");

  property p_clock_inv;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      1'b1 |=> clock_o == ($past(clk_phase_i) ^ $past(state_reg.ctrl[`OC_CLOCK_INV_BIT]));
  endproperty
  a_clock_inv: assert property (p_clock_inv) else $error("clock polarity wrong");

  property p_swing;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      reg_wr_i && reg_addr_i == `OUTPUT_SWING_OFFSET
        |=> {data_swing_o, clock_swing_o} == $past(reg_wdata_i);
  endproperty
  a_swing: assert property (p_swing) else $error("swing not stored");

  property p_adapt;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      eq_adapt_ok_o |-> adapt_s;
  endproperty
  a_adapt: assert property (p_adapt) else $error("adaptation below rate");

  // Reference mode reloads the ratio on restart, so only a loss that stays in data mode counts.
  sequence s_lost;
    (state_reg.st == ACQ_TRACK && unlock_s && !refm_s) ##1 !refm_s;
  endsequence
  property p_restart;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_lost |-> lock_lost_flag_o ##1 (dco_word_o == '0 && div_ratio_o == 4'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("restart after loss wrong");

  property p_reserved;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      state_reg.ctrl[7:6] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_lock;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      state_reg.st == ACQ_SEARCH && lockwin_s |=> phase_loop_en_o && !lock_lost_flag_o;
  endproperty
  a_lock: assert property (p_lock) else $error("phase loop not enabled at lock");
endmodule // cdr_output_and_acquisition_control

// file: verification/line_partner.sv
// Line-side partner: serial source into the block and a sink for the retimed data.
`timescale 1ns/1ps
module line_partner (
  input  wire logic ref_clk_i,   // Bench clock.
  input  wire logic rst_n_i,     // Async reset, active low.
  input  wire logic data_oe_i,   // Retimed data driver enable.
  input  wire logic data_i,      // Retimed data from the block.
  output logic      line_data_o, // Recovered data bit into the block.
  output logic      line_clk_o   // Recovered clock level into the block.
);
  int unsigned ones_seen;
  initial begin
    line_data_o = 1'b0;
    line_clk_o  = 1'b0;
    ones_seen   = 0;
  end
  // Fresh random data every cycle, so a stuck or delayed output path shows at once.
  always @(posedge ref_clk_i) begin
    line_data_o <= 1'($urandom);
    line_clk_o  <= ~line_clk_o;
    if (rst_n_i && data_oe_i && data_i === 1'b1) begin
      ones_seen <= ones_seen + 1;
    end
  end
endmodule // line_partner

// file: verification/tb_cdr_output_and_acquisition_control.sv
// Self-checking bench of the output control, swing registers and acquisition loop.
`timescale 1ns/1ps
module tb_cdr_output_and_acquisition_control;
  import cdr_ctrl_pkg::*;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, v;
  logic sample_fast_i = 1'b0, within_lock_i = 1'b0, beyond_unlock_i = 1'b0;
  logic phase_lag_i = 1'b0, phase_valid_i = 1'b0, rate_above_adapt_i = 1'b0;
  logic ref_mode_i = 1'b0, data_i, clk_phase_i, data_o, data_oe_o, clock_o, clock_oe_o;
  logic ddr_en_o, eq_adapt_ok_o, phase_loop_en_o, lock_lost_flag_o, prev_d, prev_c;
  logic [3:0] data_swing_o, clock_swing_o, div_ratio_o;
  logic [15:0] dco_word_o, d0;
  logic [4:0] shifter_o, s0;
  int miscompares = 0, cmp_count = 0, pol_on = 0;
  logic [7:0] ctrl_m = 8'h00, swing_m = 8'hcc;

  cdr_output_and_acquisition_control cdr_output_and_acquisition_control_i (.*);
  line_partner line_partner_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .data_oe_i(data_oe_o), .data_i(data_o), .line_data_o(data_i), .line_clk_o(clk_phase_i));

  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wait_for(input string n, ref logic s, input logic e);
    int k;
    k = 0;
    @(negedge ref_clk_i);
    while (s !== e && k < 20) begin
      @(negedge ref_clk_i);
      k++;
    end
    chk(n, {15'h0, e}, {15'h0, s});
    if (s !== e) end_of_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("reg_rdata_o", {8'h00, e}, {8'h00, reg_rdata_o});
  endtask

  task automatic check_outs();
    @(negedge ref_clk_i);
    chk("data_oe_o", {15'h0, ~ctrl_m[4]}, {15'h0, data_oe_o});
    chk("clock_oe_o", {15'h0, ~ctrl_m[3]}, {15'h0, clock_oe_o});
    chk("ddr_en_o", {15'h0, ~ctrl_m[2]}, {15'h0, ddr_en_o});
    chk("data_swing_o", {12'h0, swing_m[7:4]}, {12'h0, data_swing_o});
    chk("clock_swing_o", {12'h0, swing_m[3:0]}, {12'h0, clock_swing_o});
  endtask

  // Retimed outputs follow the input sampled at the previous edge.
  always @(posedge ref_clk_i) begin
    prev_d = data_i;
    prev_c = clk_phase_i;
  end
  always @(negedge ref_clk_i) begin
    if (pol_on != 0) begin
      chk("data_o", {15'h0, prev_d ^ ctrl_m[1]}, {15'h0, data_o});
      chk("clock_o", {15'h0, prev_c ^ ctrl_m[0]}, {15'h0, clock_o});
    end
  end

  initial begin
    void'($urandom(32'h4a5dc8d0));
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    check_outs();
    chk("lock_lost_flag_o", 16'h1, {15'h0, lock_lost_flag_o});
    rd(8'h1e, 8'h00);
    rd(8'h1f, 8'hcc);
    for (int i = 0; i < 12; i++) begin
      pol_on = 0;
      v = (i < 8) ? (8'h01 << i) : 8'($urandom);
      wr(8'h1e, v);
      ctrl_m = v & 8'h3f;
      repeat (3) @(posedge ref_clk_i);
      pol_on = 1;
      check_outs();
      rd(8'h1e, ctrl_m);
    end
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h4f : {4'(4 + $urandom_range(11)), 4'(4 + $urandom_range(11))};
      wr(8'h1f, v);
      swing_m = v;
      repeat (3) @(posedge ref_clk_i);
      check_outs();
      rd(8'h1f, swing_m);
    end
    wr(8'h40, 8'h5a);
    rd(8'h40, 8'h00);
    rd(8'h1f, swing_m);
    wr(8'h20, 8'h01);
    wait_for("eq_adapt_ok_o", eq_adapt_ok_o, 1'b0);
    @(posedge ref_clk_i);
    rate_above_adapt_i <= 1'b1;
    wait_for("eq_adapt_ok_o", eq_adapt_ok_o, 1'b1);
    wait_for("lock_lost_flag_o", lock_lost_flag_o, 1'b1);
    @(posedge ref_clk_i);
    sample_fast_i <= 1'b1;
    repeat (12) @(negedge ref_clk_i);
    chk("div rises", 16'h1, {15'h0, div_ratio_o != 4'h0});
    @(posedge ref_clk_i);
    sample_fast_i <= 1'b0;
    repeat (12) @(negedge ref_clk_i);
    chk("dco rises", 16'h1, {15'h0, dco_word_o != 16'h0});
    @(posedge ref_clk_i);
    within_lock_i <= 1'b1;
    wait_for("phase_loop_en_o", phase_loop_en_o, 1'b1);
    wait_for("lock_lost_flag_o", lock_lost_flag_o, 1'b0);
    d0 = dco_word_o;
    s0 = shifter_o;
    @(posedge ref_clk_i);
    phase_valid_i <= 1'b1;
    phase_lag_i <= 1'b1;
    repeat (10) @(negedge ref_clk_i);
    chk("dco up on lag", 16'h1, {15'h0, dco_word_o > d0});
    chk("shifter moves", 16'h1, {15'h0, shifter_o != s0});
    @(posedge ref_clk_i);
    beyond_unlock_i <= 1'b1;
    wait_for("lock_lost_flag_o", lock_lost_flag_o, 1'b1);
    wait_for("phase_loop_en_o", phase_loop_en_o, 1'b0);
    repeat (2) @(negedge ref_clk_i);
    chk("dco_word_o", 16'h0, dco_word_o);
    chk("div_ratio_o", 16'h0, {12'h0, div_ratio_o});
    // Loss seen one cycle before the mode pin, so the restart loads the written ratio.
    wr(8'h22, 8'h05);
    beyond_unlock_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    beyond_unlock_i <= 1'b1;
    @(posedge ref_clk_i);
    ref_mode_i <= 1'b1;
    repeat (6) @(negedge ref_clk_i);
    chk("div_ratio_o", 16'h5, {12'h0, div_ratio_o});
    chk("phase_loop_en_o", 16'h1, {15'h0, phase_loop_en_o});
    chk("ones_seen", 16'h1, {15'h0, line_partner_i.ones_seen != 0});
    end_of_test();
  end
endmodule // tb_cdr_output_and_acquisition_control
